//--- hw/usbg_pkg.sv
`default_nettype none
package usbg_pkg;
   // register byte offsets
   localparam logic [7:0]  ADR_MODE    = 8'h00;
   localparam logic [7:0]  ADR_DIV     = 8'h04;
   localparam logic [7:0]  ADR_RATIO   = 8'h08;
   localparam logic [7:0]  ADR_CMD     = 8'h0c;
   localparam logic [7:0]  ADR_STAT    = 8'h10;
   localparam logic [7:0]  ADR_CODE    = 8'h14;
   // port_mode_register fields
   localparam int          MODE_SYNC   = 0;
   localparam int          MODE_OVER   = 1;
   localparam int          MODE_SC     = 2;
   localparam int          MODE_CSS_LO = 4;
   localparam int          MODE_CLOCK_OUTPUT_ENABLE   = 6;
   localparam logic [6:0]  MODE_RST    = 7'h00;
   // baud_divisor_register fields
   localparam int          DIV_FP_LO   = 16;
   localparam logic [15:0] CD_RST      = 16'h0000;
   localparam logic [2:0]  FP_RST      = 3'h0;
   // time_unit_ratio_register
   localparam logic [10:0] RATIO_RST   = 11'h174;
   // code register: bit_rate_adjust_code [3:0], clock_division_code [7:4]
   localparam int          CODE_FI_LO  = 4;
   localparam logic [7:0]  CODE_RST    = 8'h11;
   // port_command_register bits
   localparam int          CMD_RX_RST  = 2;
   localparam int          CMD_TX_RST  = 3;
   localparam int          CMD_RX_EN   = 4;
   localparam int          CMD_RX_DIS  = 5;
   localparam int          CMD_TX_EN   = 6;
   localparam int          CMD_TX_DIS  = 7;
   // clock_source_select values
   localparam logic [1:0]  CSS_MCK     = 2'h0;
   localparam logic [1:0]  CSS_DIV     = 2'h1;
   localparam logic [1:0]  CSS_EXT     = 2'h3;
   // prescaler (divide by 8) and oversampling wraps
   localparam logic [2:0]  PRE_LAST    = 3'h7;
   localparam logic [3:0]  OS16_LAST   = 4'hf;
   localparam logic [3:0]  OS8_LAST    = 4'h7;

   function automatic logic [5:0] di_value(input logic [3:0] code);
      unique case (code)
         4'h1:    di_value = 6'h01;
         4'h2:    di_value = 6'h02;
         4'h3:    di_value = 6'h04;
         4'h4:    di_value = 6'h08;
         4'h5:    di_value = 6'h10;
         4'h6:    di_value = 6'h20;
         4'h8:    di_value = 6'h0c;
         4'h9:    di_value = 6'h14;
         default: di_value = 6'h00;
      endcase
   endfunction : di_value

   function automatic logic [11:0] fi_value(input logic [3:0] code);
      unique case (code)
         4'h0, 4'h1: fi_value = 12'h174;
         4'h2:       fi_value = 12'h22e;
         4'h3:       fi_value = 12'h2e8;
         4'h4:       fi_value = 12'h45c;
         4'h5:       fi_value = 12'h5d0;
         4'h6:       fi_value = 12'h744;
         4'h9:       fi_value = 12'h200;
         4'ha:       fi_value = 12'h300;
         4'hb:       fi_value = 12'h400;
         4'hc:       fi_value = 12'h600;
         4'hd:       fi_value = 12'h800;
         default:    fi_value = 12'h000;
      endcase
   endfunction : fi_value
endpackage : usbg_pkg
`default_nettype wire

//--- hw/usbg_div.sv
`default_nettype none
module usbg_div
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        src_tick_i,
   input  wire logic [15:0] div_i,
   input  wire logic [2:0]  frac_i,
   output logic             tick_o,
   output logic             level_o
);
   import usbg_pkg::*;

   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [2:0]  acc;
   logic [2:0]  next_acc;
   logic        extra;
   logic        next_extra;
   logic [16:0] per;
   logic [3:0]  sum;

   // period is div_i source ticks, stretched by one whenever the
   // eighths accumulator carries: average div_i + frac_i/8
   always_comb
   begin
      next_cnt   = cnt;
      next_acc   = acc;
      next_extra = extra;
      tick_o     = 1'b0;
      per        = {1'b0, div_i} + {16'h0000, extra};
      sum        = {1'b0, acc} + {1'b0, frac_i};
      if (div_i == 16'h0000)
      begin
         next_cnt   = 16'h0000;
         next_acc   = 3'h0;
         next_extra = 1'b0;
      end
      else if (src_tick_i)
      begin
         if ({1'b0, cnt} >= per - 17'h00001)
         begin
            next_cnt   = 16'h0000;
            tick_o     = 1'b1;
            next_acc   = sum[2:0];
            next_extra = sum[3];
         end
         else
         begin
            next_cnt = cnt + 16'h0001;
         end
      end
      level_o = ({1'b0, cnt} < (per >> 1));
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt   <= 16'h0000;
         acc   <= 3'h0;
         extra <= 1'b0;
      end
      else if (ce_i)
      begin
         cnt   <= next_cnt;
         acc   <= next_acc;
         extra <= next_extra;
      end
   end
endmodule : usbg_div
`default_nettype wire

//--- hw/usbg_top.sv
// Function
// - async, 16x oversampling: baud = selected clock / (divisor * 16)
// - nonzero fractional part adds eighth-step division to the divisor
// - fractional division acts only in normal asynchronous mode
// - synchronous mode: bit clock = selected clock / divisor, no oversampling
// - synchronous with source 3: serial clock pin is bit clock, undivided
// - undivided master clock source: serial clock pin kept near 50:50, except divisor 0, and divisor 1 with no fractional part in effect, hold it low
// - bit-rate adjust code decodes to 1,2,4,8,16,32,12,20
// - clock-division code decodes to 372..1860 and 512..2048
// - smart-card: source / divisor is card clock, driven when output enabled and source is not 3
// - smart-card: card clock / time-unit ratio, up to 2047, is bit clock
// - time-unit ratio resets to 0x174 (372)
// - receiver off after reset until enable command; config writable
// - transmitter off after reset until enable command; config writable
// - receiver and transmitter enabled together or separately
// - reset command stops direction at once; configuration is kept
// - receiver disable finishes the current character first
// - transmitter disable finishes current and held character first
// - 16-bit divisor; 0 stops the baud clock except synchronous with source 3, 1 bypasses the divider
// - source select: master clock, master clock / 8, serial clock pin
// - oversample select 1 samples at 8x baud, 0 at 16x
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module usbg_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe_o,
   input  wire logic        rx_busy_i,
   input  wire logic        tx_busy_i,
   output logic             sample_tick_o,
   output logic             baud_tick_o,
   output logic             rx_enabled_o,
   output logic             tx_enabled_o,
   output logic             rx_reset_o,
   output logic             tx_reset_o
);
   import usbg_pkg::*;

   typedef enum logic [1:0] {USBG_OFF, USBG_ON, USBG_DRAIN} usbg_dir_e;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  sel);
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            old[8*i +: 8] = val[8*i +: 8];
         end
      end
      merge = old;
   endfunction : merge

   function automatic usbg_dir_e dir_next(input usbg_dir_e st,
                                          input logic rst,
                                          input logic en,
                                          input logic dis,
                                          input logic busy);
      if (rst)
         dir_next = USBG_OFF;
      else if (dis)
         dir_next = (st != USBG_OFF && busy) ? USBG_DRAIN : USBG_OFF;
      else if (en)
         dir_next = USBG_ON;
      else if (st == USBG_DRAIN && !busy)
         dir_next = USBG_OFF;
      else
         dir_next = st;
   endfunction : dir_next

   // register file state
   logic        sync_mode, over, sc_mode, clock_output_enable;
   logic [1:0]  css;
   logic [15:0] cd;
   logic [2:0]  fp;
   logic [10:0] ratio;
   logic [7:0]  codes;
   usbg_dir_e   rx_st, tx_st;
   logic        next_sync_mode, next_over, next_sc_mode, next_clock_output_enable;
   logic [1:0]  next_css;
   logic [15:0] next_cd;
   logic [2:0]  next_fp;
   logic [10:0] next_ratio;
   logic [7:0]  next_codes;
   usbg_dir_e   next_rx_st, next_tx_st;
   logic [31:0] next_dat;
   logic        next_ack;
   logic        req, wr;
   logic [7:0]  cmd;
   logic [31:0] mode_word, div_word, tmp;

   always_comb
   begin
      req       = cyc_i & stb_i;
      wr        = req & we_i & ack_o;
      mode_word = {25'h0000000, clock_output_enable, css, 1'b0, sc_mode, over, sync_mode};
      div_word  = {13'h0000, fp, cd};
      next_sync_mode = sync_mode;
      next_over      = over;
      next_sc_mode   = sc_mode;
      next_clock_output_enable      = clock_output_enable;
      next_css       = css;
      next_cd        = cd;
      next_fp        = fp;
      next_ratio     = ratio;
      next_codes     = codes;
      cmd            = 8'h00;
      tmp            = 32'h00000000;
      // configuration is writable whatever the enable state
      if (wr)
      begin
         unique case (adr_i)
            ADR_MODE:
            begin
               tmp = merge(mode_word, dat_i, sel_i);
               next_sync_mode = tmp[MODE_SYNC];
               next_over      = tmp[MODE_OVER];
               next_sc_mode   = tmp[MODE_SC];
               next_css       = tmp[MODE_CSS_LO +: 2];
               next_clock_output_enable      = tmp[MODE_CLOCK_OUTPUT_ENABLE];
            end
            ADR_DIV:
            begin
               tmp     = merge(div_word, dat_i, sel_i);
               next_cd = tmp[15:0];
               next_fp = tmp[DIV_FP_LO +: 3];
            end
            ADR_RATIO:
            begin
               tmp        = merge({21'h000000, ratio}, dat_i, sel_i);
               next_ratio = tmp[10:0];
            end
            ADR_CODE:
            begin
               tmp        = merge({24'h000000, codes}, dat_i, sel_i);
               next_codes = tmp[7:0];
            end
            ADR_CMD:
            begin
               cmd = sel_i[0] ? dat_i[7:0] : 8'h00;
            end
            default:
            begin
               tmp = 32'h00000000;
            end
         endcase
      end
      // both directions decoded from one write independently
      next_rx_st = dir_next(rx_st, cmd[CMD_RX_RST], cmd[CMD_RX_EN],
                            cmd[CMD_RX_DIS], rx_busy_i);
      next_tx_st = dir_next(tx_st, cmd[CMD_TX_RST], cmd[CMD_TX_EN],
                            cmd[CMD_TX_DIS], tx_busy_i);
      next_ack = req & ~ack_o;
      next_dat = 32'h00000000;
      if (req & ~ack_o & ~we_i)
      begin
         unique case (adr_i)
            ADR_MODE:  next_dat = mode_word;
            ADR_DIV:   next_dat = div_word;
            ADR_RATIO: next_dat = {21'h000000, ratio};
            ADR_STAT:  next_dat = {28'h0000000, tx_st == USBG_DRAIN,
                                   rx_st == USBG_DRAIN, tx_st != USBG_OFF,
                                   rx_st != USBG_OFF};
            ADR_CODE:  next_dat = {4'h0, fi_value(codes[CODE_FI_LO +: 4]),
                                   2'h0, di_value(codes[3:0]), codes};
            default:   next_dat = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         {clock_output_enable, css, sc_mode, over, sync_mode} <= MODE_RST[5:0];
         cd           <= CD_RST;
         fp           <= FP_RST;
         ratio        <= RATIO_RST;
         codes        <= CODE_RST;
         rx_st        <= USBG_OFF;
         tx_st        <= USBG_OFF;
         ack_o        <= 1'b0;
         dat_o        <= 32'h00000000;
         rx_enabled_o <= 1'b0;
         tx_enabled_o <= 1'b0;
         rx_reset_o   <= 1'b0;
         tx_reset_o   <= 1'b0;
      end
      else if (ce_i)
      begin
         sync_mode    <= next_sync_mode;
         over         <= next_over;
         sc_mode      <= next_sc_mode;
         clock_output_enable         <= next_clock_output_enable;
         css          <= next_css;
         cd           <= next_cd;
         fp           <= next_fp;
         ratio        <= next_ratio;
         codes        <= next_codes;
         rx_st        <= next_rx_st;
         tx_st        <= next_tx_st;
         ack_o        <= next_ack;
         dat_o        <= next_dat;
         rx_enabled_o <= next_rx_st != USBG_OFF;
         tx_enabled_o <= next_tx_st != USBG_OFF;
         rx_reset_o   <= cmd[CMD_RX_RST];
         tx_reset_o   <= cmd[CMD_TX_RST];
      end
   end

   // clock generation state
   logic       sck_s1, sck_s2, sck_s3;
   logic [2:0] pre_cnt, next_pre_cnt;
   logic [3:0] os_cnt, next_os_cnt;
   logic       next_sck, next_sck_oe, next_sample, next_baud;
   logic       ext_rise, src_tick, div_tick, div_lvl, ratio_tick;
   logic [2:0] fp_eff;

   usbg_div u_cd_div
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .src_tick_i (src_tick),
      .div_i      (cd),
      .frac_i     (fp_eff),
      .tick_o     (div_tick),
      .level_o    (div_lvl)
   );

   usbg_div u_ratio_div
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .src_tick_i (div_tick & sc_mode),
      .div_i      ({5'h00, ratio}),
      .frac_i     (3'h0),
      .tick_o     (ratio_tick),
      .level_o    ()
   );

   always_comb
   begin
      ext_rise     = sck_s2 & ~sck_s3;
      next_pre_cnt = pre_cnt + 3'h1;
      fp_eff       = (sync_mode | sc_mode) ? 3'h0 : fp;
      unique case (css)
         CSS_DIV: src_tick = (pre_cnt == PRE_LAST);
         CSS_EXT: src_tick = ext_rise;
         default: src_tick = 1'b1;
      endcase
      next_os_cnt = os_cnt;
      next_sample = 1'b0;
      next_baud   = 1'b0;
      if (sc_mode)
      begin
         next_baud = ratio_tick;
      end
      else if (sync_mode)
      begin
         next_baud = (css == CSS_EXT) ? ext_rise : div_tick;
      end
      else if (div_tick)
      begin
         next_sample = 1'b1;
         if (os_cnt == (over ? OS8_LAST : OS16_LAST))
         begin
            next_os_cnt = 4'h0;
            next_baud   = 1'b1;
         end
         else
         begin
            next_os_cnt = os_cnt + 4'h1;
         end
      end
      next_sck_oe = clock_output_enable & (css != CSS_EXT);
      next_sck    = next_sck_oe & div_lvl;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sck_s1        <= 1'b0;
         sck_s2        <= 1'b0;
         sck_s3        <= 1'b0;
         pre_cnt       <= 3'h0;
         os_cnt        <= 4'h0;
         sck_o         <= 1'b0;
         sck_oe_o      <= 1'b0;
         sample_tick_o <= 1'b0;
         baud_tick_o   <= 1'b0;
      end
      else if (ce_i)
      begin
         sck_s1        <= sck_i;
         sck_s2        <= sck_s1;
         sck_s3        <= sck_s2;
         pre_cnt       <= next_pre_cnt;
         os_cnt        <= next_os_cnt;
         sck_o         <= next_sck;
         sck_oe_o      <= next_sck_oe;
         sample_tick_o <= next_sample;
         baud_tick_o   <= next_baud;
      end
   end

   logic cmd_q;
   always_ff @(posedge clk_i)
   begin
      cmd_q <= ce_i & (cmd != 8'h00);
   end

   // cycles since the last mode or divisor write, saturating
   logic [4:0] cfg_age, next_cfg_age;
   always_comb
   begin
      next_cfg_age = (cfg_age == 5'h1f) ? cfg_age : cfg_age + 5'h01;
      if (wr && (adr_i == ADR_MODE || adr_i == ADR_DIV))
         next_cfg_age = 5'h00;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg_age <= 5'h00;
      else if (ce_i)
         cfg_age <= next_cfg_age;
   end

   chk_ratio_reset: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> ratio == RATIO_RST)
      else $error("ratio reset value wrong");
   chk_off_after_reset: assert property (@(posedge clk_i)
      $past(rst_i) && !rst_i |-> !rx_enabled_o && !tx_enabled_o)
      else $error("direction enabled after reset");
   chk_rx_reset_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && cmd[CMD_RX_RST] |=> !rx_enabled_o && rx_reset_o)
      else $error("receiver reset did not stop it");
   chk_disable_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && cmd[CMD_TX_EN] && cmd[CMD_TX_DIS] && !cmd[CMD_TX_RST]
      && !tx_busy_i |=> !tx_enabled_o)
      else $error("enable beat disable");
   chk_rx_drain: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rx_enabled_o && cmd[CMD_RX_DIS] && !cmd[CMD_RX_RST]
      && rx_busy_i |=> rx_enabled_o)
      else $error("receiver stopped mid character");
   chk_tx_drain_end: assert property (@(posedge clk_i)
      disable iff (rst_i || !ce_i)
      tx_st == USBG_DRAIN && !tx_busy_i && cmd == 8'h00 |=> !tx_enabled_o)
      else $error("transmitter did not stop after drain");
   chk_both_enable: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && cmd == 8'h50 |=> rx_enabled_o && tx_enabled_o)
      else $error("joint enable failed");
   chk_cd_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      cd == 16'h0000 && !(sync_mode && css == CSS_EXT)
      && $past(cd) == 16'h0000 |=> !sample_tick_o && !baud_tick_o)
      else $error("tick with zero divisor");
   chk_os16_period: assert property (@(posedge clk_i)
      disable iff (rst_i || !ce_i)
      !sync_mode && !sc_mode && !over && cd == 16'h0001 && css == CSS_MCK
      && fp_eff == 3'h0 && cfg_age >= 5'h14 && baud_tick_o
      |-> $past(baud_tick_o, 16))
      else $error("16x baud period wrong");
   chk_os8_period: assert property (@(posedge clk_i)
      disable iff (rst_i || !ce_i)
      !sync_mode && !sc_mode && over && cd == 16'h0001 && css == CSS_MCK
      && fp_eff == 3'h0 && cfg_age >= 5'h14 && baud_tick_o
      |-> $past(baud_tick_o, 8))
      else $error("8x baud period wrong");
   chk_sync_ext: assert property (@(posedge clk_i)
      disable iff (rst_i || !ce_i)
      sync_mode && !sc_mode && css == CSS_EXT && ext_rise && !wr
      |=> baud_tick_o)
      else $error("external edge not used as bit clock");

   cov_rx_drain: cover property (@(posedge clk_i) rx_st == USBG_DRAIN);
   cov_sc_bit: cover property (@(posedge clk_i) sc_mode && baud_tick_o);
   cov_frac: cover property (@(posedge clk_i) fp_eff != 3'h0 && baud_tick_o);
   cov_cmd: cover property (@(posedge clk_i) cmd_q);
endmodule : usbg_top
`default_nettype wire

//--- verif/usbg_far.sv
`default_nettype none
module usbg_far
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic sck_run_i,
   input  wire logic rx_go_i,
   input  wire logic tx_go_i,
   output logic      sck_o,
   output logic      rx_busy_o,
   output logic      tx_busy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph;
   logic [4:0] rx_n;
   logic [4:0] tx_n;
   // serial clock: 3-cycle half period, still and low when not running
   always @(posedge clk_i)
   begin
      if (rst_i || !sck_run_i)
      begin
         ph <= 2'h0;
         sck_o <= 1'b0;
      end
      else if (ph == 2'h2)
      begin
         ph <= 2'h0;
         sck_o <= !sck_o;
      end
      else
         ph <= ph + 2'h1;
      // one character in flight lasts 20 cycles
      rx_n <= rst_i ? 5'h00 : rx_go_i ? 5'h14 : rx_n - {4'h0, rx_n != 5'h00};
      tx_n <= rst_i ? 5'h00 : tx_go_i ? 5'h14 : tx_n - {4'h0, tx_n != 5'h00};
   end
   assign rx_busy_o = (rx_n != 5'h00);
   assign tx_busy_o = (tx_n != 5'h00);
endmodule : usbg_far
`default_nettype wire

//--- verif/usbg_top_test.sv
`default_nettype none
module usbg_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   import usbg_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, d, code;
   logic        sck_out, sck_oe, far_sck, rx_busy, tx_busy, stk, btk;
   logic        rx_en, tx_en, rx_rst, tx_rst, sck_run, rx_go, tx_go;
   wire logic   sck_pin;
   logic [31:0] exp_q[$];
   int          fails, check_count, rst_pulses, i;
   integer      seed;
   int di_c[8] = '{1, 2, 3, 4, 5, 6, 8, 9};
   int di_v[8] = '{1, 2, 4, 8, 16, 32, 12, 20};
   int fi_c[12] = '{0, 1, 2, 3, 4, 5, 6, 9, 10, 11, 12, 13};
   int fi_v[12] = '{372, 372, 558, 744, 1116, 1488, 1860, 512, 768, 1024,
                    1536, 2048};
   int t_mode[10] = '{'h00, 'h02, 'h02, 'h12, 'h11, 'h44, 'h31, 'h00, 'h02,
                      'h00};
   int t_div[10] = '{3, 3, 'h40003, 1, 'h40002, 'h40002, 2, 1, 1, 0};
   int t_exp[10] = '{48, 24, 28, 64, 16, 10, 6, 16, 8, 0};

   // pin level from the design's output enable: its clock when set, else the far end's clock
   assign sck_pin = sck_oe ? sck_out : far_sck;

   usbg_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .sck_i(sck_pin), .sck_o(sck_out),
      .sck_oe_o(sck_oe), .rx_busy_i(rx_busy), .tx_busy_i(tx_busy),
      .sample_tick_o(stk), .baud_tick_o(btk), .rx_enabled_o(rx_en),
      .tx_enabled_o(tx_en), .rx_reset_o(rx_rst), .tx_reset_o(tx_rst));

   usbg_far far (.clk_i(clk_i), .rst_i(rst_i), .sck_run_i(sck_run),
      .rx_go_i(rx_go), .tx_go_i(tx_go), .sck_o(far_sck),
      .rx_busy_o(rx_busy), .tx_busy_o(tx_busy));

   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] dd, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dd;
      sel <= s;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1)
      begin
         fails++;
         $display("ERROR %0t bus answer missing", $time);
         complete_run();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] dd);
      wb(1'b1, a, dd, 4'hf);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask : rd

   // interval between the second and third baud tick
   task automatic per(input int e);
      int n;
      int k;
      for (k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge clk_i);
            n++;
         end
         while (btk !== 1'b1 && n < 3000);
      end
      check(32'(n), 32'(e == 0 ? 3000 : e));
   endtask : per

   // read data is compared against the oldest note
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
         check(rdat, exp_q.pop_front());
      if (rx_rst === 1'b1)
         rst_pulses++;
   end

   initial
   begin
      seed = 32'h003b;
      {cyc, stb, we, sck_run, rx_go, tx_go} = 6'h00;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_RATIO, 32'h174);
      rd(ADR_CODE, 32'h0174_0111);
      rd(ADR_STAT, 32'h0);
      rd(8'h1c, 32'h0);
      $display("reset values done");
      for (i = 0; i < 13; i++)
      begin
         code = (i == 12) ? 32'h77 : 32'(fi_c[i] * 16 + di_c[i % 8]);
         wr(ADR_CODE, code);
         if (i == 12)
            rd(ADR_CODE, 32'h77);
         else
            rd(ADR_CODE, 32'(fi_v[i] * 65536 + di_v[i % 8] * 256) | code);
      end
      $display("code decode done");
      d = $random(seed);
      wr(ADR_DIV, d);
      rd(ADR_DIV, d & 32'h0007_ffff);
      wb(1'b1, ADR_DIV, 32'hffff_ffff, 4'h1);
      rd(ADR_DIV, (d & 32'h0007_ff00) | 32'hff);
      $display("divisor access done");
      wr(ADR_RATIO, 32'h5);
      for (i = 0; i < 10; i++)
      begin
         sck_run <= (i == 6);
         wr(ADR_MODE, 32'(t_mode[i]));
         wr(ADR_DIV, 32'(t_div[i]));
         per(t_exp[i]);
         if (i == 5)
            check({31'h0, sck_oe}, 32'h1);
      end
      sck_run <= 1'b0;
      $display("tick rates done");
      wr(ADR_CMD, 32'h30);
      wr(ADR_CMD, 32'hc0);
      rd(ADR_STAT, 32'h0);
      wr(ADR_CMD, 32'h40);
      rd(ADR_STAT, 32'h2);
      wr(ADR_CMD, 32'h10);
      rd(ADR_STAT, 32'h3);
      rx_go <= 1'b1;
      tx_go <= 1'b1;
      @(posedge clk_i);
      rx_go <= 1'b0;
      tx_go <= 1'b0;
      wr(ADR_CMD, 32'ha0);
      rd(ADR_STAT, 32'hf);
      repeat (30) @(posedge clk_i);
      rd(ADR_STAT, 32'h0);
      check({30'h0, rx_en, tx_en}, 32'h0);
      $display("enable and drain done");
      wr(ADR_CMD, 32'h50);
      rx_go <= 1'b1;
      @(posedge clk_i);
      rx_go <= 1'b0;
      wr(ADR_CMD, 32'h04);
      rd(ADR_STAT, 32'h2);
      rd(ADR_RATIO, 32'h5);
      check(32'(rst_pulses), 32'h1);
      $display("direction reset done");
      complete_run();
   end
endmodule : usbg_top_test
`default_nettype wire
